// ---- logic/sleep_wake_control.sv ----
// Purpose: Power-down entry and wake-up control with watchdog handling
// Assumes: Core pulses and interrupt sources are on the pclk domain
// Notes:   Block keeps running while the core oscillator is stopped
`timescale 1ns/1ps
`include "swc_cfg.svh"

module sleep_wake_control
  import swc_pkg::*;
#(
  parameter int N_SRC = 8
) (
  // Clock and reset
  input  wire logic              pclk,
  input  wire logic              presetn,
  // APB slave
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [11:0]       paddr,
  input  wire logic [31:0]       pwdata,
  output logic                   pready,
  output logic [31:0]            prdata,
  output logic                   pslverr,
  // Interrupt sources
  input  wire logic [N_SRC-1:0]  src_enable,
  input  wire logic [N_SRC-1:0]  src_flag,
  // Core instruction stream
  input  wire logic              sleep_exec,
  input  wire logic              wd_clear_exec,
  input  wire logic              instr_retired,
  output logic                   osc_stop,
  output logic                   core_halt,
  output logic                   resume,
  output logic                   vector_take,
  output logic [12:0]            vector_addr,
  output logic                   wdt_reset_req,
  // Interrupt
  output logic                   irq
);

  swc_state_type             state_reg, state_next;
  logic [1:0]                ctrl_reg, ctrl_next;
  logic                      to_reg, to_next;
  logic                      pdown_reg, pdown_next;
  logic [`SWC_EV_W-1:0]      ist_reg, ist_next;
  logic [`SWC_EV_W-1:0]      imask_reg, imask_next;
  logic                      wake_prev_reg;
  logic                      resume_reg, resume_next;
  logic                      vec_reg, vec_next;
  logic [31:0]               rdata_reg, rdata_next;
  logic                      err_reg, err_next;
  logic                      wake_cond;
  logic                      global_int_en;
  logic                      sleep_nop;
  logic                      sleep_go;
  logic                      wake_now;
  logic                      wdt_clear;
  logic                      wdt_to;
  logic [7:0]                wdt_count;
  logic                      wr_en;
  logic                      setup;
  logic [`SWC_EV_W-1:0]      ev;

  assign global_int_en = ctrl_reg[`SWC_CTRL_GLOBAL_EN];

  // Wake condition from enable and flag pairs
  assign wake_cond = |(src_enable & src_flag);

  // Sleep outcome: pending before the instruction makes it a no-op
  assign sleep_nop = (state_reg == SWC_AWAKE) && sleep_exec && wake_prev_reg;
  assign sleep_go  = (state_reg == SWC_AWAKE) && sleep_exec && !wake_prev_reg;

  // Wake from interrupt or watchdog while asleep
  assign wake_now = (state_reg == SWC_ASLEEP) && (wake_cond || wdt_to);

  // Watchdog clear on sleep, wake and software clear
  assign wdt_clear = sleep_go || wake_now || wd_clear_exec;

  swc_wdt #(
    .PRE_W  (4),
    .CNT_W  (8),
    .POST_W (2)
  ) u_wdt (
    .pclk    (pclk),
    .presetn (presetn),
    .enable  (ctrl_reg[`SWC_CTRL_WDT_EN]),
    .clear   (wdt_clear),
    .count   (wdt_count),
    .timeout (wdt_to)
  );

  // Power state sequencing
  always_comb begin
    state_next  = state_reg;
    resume_next = 1'b0;
    vec_next    = 1'b0;
    unique case (state_reg)
      SWC_AWAKE: begin
        if (sleep_go) begin
          state_next = SWC_ASLEEP;
        end
      end
      SWC_ASLEEP: begin
        if (wake_now) begin
          resume_next = 1'b1;
          state_next  = (global_int_en && wake_cond && !wdt_to) ? SWC_PEND_VEC : SWC_AWAKE;
        end
      end
      SWC_PEND_VEC: begin
        if (instr_retired) begin
          vec_next   = 1'b1;
          state_next = SWC_AWAKE;
        end
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg     <= SWC_AWAKE;
      resume_reg    <= 1'b0;
      vec_reg       <= 1'b0;
      wake_prev_reg <= 1'b0;
    end else begin
      state_reg     <= state_next;
      resume_reg    <= resume_next;
      vec_reg       <= vec_next;
      wake_prev_reg <= wake_cond;
    end
  end

  assign osc_stop      = (state_reg == SWC_ASLEEP);
  assign core_halt     = (state_reg == SWC_ASLEEP);
  assign resume        = resume_reg;
  assign vector_take   = vec_reg;
  assign vector_addr   = `SWC_VECTOR;
  assign wdt_reset_req = wdt_to && (state_reg != SWC_ASLEEP);

  // APB phase decode
  assign setup = psel && !penable;
  assign wr_en = psel && penable && pwrite && !err_reg;

  // Status flags; no-op sleep leaves both untouched
  always_comb begin
    to_next = to_reg;
    pdown_next = pdown_reg;
    if (sleep_go || wd_clear_exec) begin
      to_next    = 1'b1;
      pdown_next = !sleep_go;
    end
    if (wdt_to) begin
      to_next = 1'b0;
    end
  end

  // Events, set wins over write-one-to-clear
  always_comb begin
    ev = '0;
    ev[`SWC_EV_SLEEP] = sleep_go;
    ev[`SWC_EV_NOP]   = sleep_nop;
    ev[`SWC_EV_WAKE]  = wake_now;
    ev[`SWC_EV_WDT]   = wdt_to;
    ctrl_next  = ctrl_reg;
    imask_next = imask_reg;
    ist_next   = ist_reg;
    if (wr_en && paddr == `SWC_ADDR_CTRL) begin
      ctrl_next = pwdata[1:0];
    end
    if (wr_en && paddr == `SWC_ADDR_INT_MASK) begin
      imask_next = pwdata[`SWC_EV_W-1:0];
    end
    if (wr_en && paddr == `SWC_ADDR_INT_STAT) begin
      ist_next = ist_reg & ~pwdata[`SWC_EV_W-1:0];
    end
    ist_next = ist_next | ev;
  end

  // Read data and error captured in the setup cycle
  always_comb begin
    rdata_next = rdata_reg;
    err_next   = err_reg;
    if (setup) begin
      rdata_next = '0;
      err_next   = 1'b0;
      unique case (paddr)
        `SWC_ADDR_CTRL:     rdata_next[1:0] = ctrl_reg;
        `SWC_ADDR_STATUS: begin
          rdata_next[`SWC_ST_TIMEOUT]   = to_reg;
          rdata_next[`SWC_ST_POWERDOWN] = pdown_reg;
          rdata_next[`SWC_ST_ASLEEP]    = (state_reg == SWC_ASLEEP);
          rdata_next[15:8]              = wdt_count;
        end
        `SWC_ADDR_INT_STAT: rdata_next[`SWC_EV_W-1:0] = ist_reg;
        `SWC_ADDR_INT_MASK: rdata_next[`SWC_EV_W-1:0] = imask_reg;
        default:            err_next = 1'b1;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_reg  <= `SWC_CTRL_RST;
      to_reg    <= `SWC_TIMEOUT_RST;
      pdown_reg <= `SWC_POWERDOWN_RST;
      ist_reg   <= '0;
      imask_reg <= '0;
      rdata_reg <= '0;
      err_reg   <= 1'b0;
    end else begin
      ctrl_reg  <= ctrl_next;
      to_reg    <= to_next;
      pdown_reg <= pdown_next;
      ist_reg   <= ist_next;
      imask_reg <= imask_next;
      rdata_reg <= rdata_next;
      err_reg   <= err_next;
    end
  end

  // Bus answers and interrupt line
  assign pready  = 1'b1;
  assign prdata  = rdata_reg;
  assign pslverr = psel && penable && err_reg;
  assign irq     = |(ist_reg & imask_reg);

endmodule : sleep_wake_control

// ---- logic/swc_cfg.svh ----
// Purpose: Offsets, field positions, reset values and timing counts
// Assumes: 32-bit APB, word aligned registers
// Notes:   Included by the sleep and wake controller files
`ifndef SWC_CFG_SVH
`define SWC_CFG_SVH

// Register byte offsets
`define SWC_ADDR_CTRL     12'h000
`define SWC_ADDR_STATUS   12'h004
`define SWC_ADDR_INT_STAT 12'h008
`define SWC_ADDR_INT_MASK 12'h00c

// Control fields
`define SWC_CTRL_GLOBAL_EN 0
`define SWC_CTRL_WDT_EN   1
`define SWC_CTRL_RST      2'h2

// Status fields
`define SWC_ST_TIMEOUT    0
`define SWC_ST_POWERDOWN  1
`define SWC_ST_ASLEEP     2

// Event bits of the interrupt status
`define SWC_EV_SLEEP      0
`define SWC_EV_NOP        1
`define SWC_EV_WAKE       2
`define SWC_EV_WDT        3
`define SWC_EV_W          4

// Power-up values of the status flags
`define SWC_TIMEOUT_RST   1'h1
`define SWC_POWERDOWN_RST 1'h1

// Interrupt vector and watchdog load value
`define SWC_VECTOR        13'h0004
`define SWC_WDT_LOAD      8'h00

`endif

// ---- logic/swc_pkg.sv ----
// Purpose: Types shared by the sleep and wake controller
// Assumes: Nothing
// Notes:   Offsets and values live in swc_cfg.svh
package swc_pkg;

  // Power state of the core
  typedef enum logic [1:0] {
    SWC_AWAKE,
    SWC_ASLEEP,
    SWC_PEND_VEC
  } swc_state_type;

endpackage : swc_pkg

// ---- logic/swc_wdt.sv ----
// Purpose: Watchdog counter with prescaler and postscaler
// Assumes: Clear pulse from the sleep and wake controller
// Notes:   Timeout is a one-cycle pulse; counting restarts after it
`timescale 1ns/1ps
`include "swc_cfg.svh"

module swc_wdt #(
  parameter int PRE_W  = 4,
  parameter int CNT_W  = 8,
  parameter int POST_W = 2
) (
  // Clock and reset
  input  wire logic             pclk,
  input  wire logic             presetn,
  // Control
  input  wire logic             enable,
  input  wire logic             clear,
  // Status
  output logic [CNT_W-1:0]      count,
  output logic                  timeout
);

  logic [PRE_W-1:0]  pre_reg,  pre_next;
  logic [CNT_W-1:0]  cnt_reg,  cnt_next;
  logic [POST_W-1:0] post_reg, post_next;
  logic              to_reg,   to_next;

  // Next values of the three counting stages
  always_comb begin
    pre_next  = pre_reg;
    cnt_next  = cnt_reg;
    post_next = post_reg;
    to_next   = 1'b0;
    if (clear) begin
      pre_next  = '0;
      cnt_next  = CNT_W'(`SWC_WDT_LOAD);
      post_next = '0;
    end else if (enable) begin
      pre_next = pre_reg + 1'b1;
      if (&pre_reg) begin
        cnt_next = cnt_reg + 1'b1;
        if (&cnt_reg) begin
          post_next = post_reg + 1'b1;
          to_next   = &post_reg;   // Last stage wraps
        end
      end
    end
  end

  // State registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pre_reg  <= '0;
      cnt_reg  <= '0;
      post_reg <= '0;
      to_reg   <= 1'b0;
    end else begin
      pre_reg  <= pre_next;
      cnt_reg  <= cnt_next;
      post_reg <= post_next;
      to_reg   <= to_next;
    end
  end

  assign count   = cnt_reg;
  assign timeout = to_reg;

endmodule : swc_wdt

// ---- verif/swc_core_model.sv ----
// Purpose: Core model that retires the instruction after wake
// Assumes: Two cycles per instruction after resume
// Notes:   Drives only instr_retired
`timescale 1ns/1ps
module swc_core_model (
  // Clock and reset
  input  wire logic pclk,
  input  wire logic presetn,
  // Core handshake
  input  wire logic resume,
  output logic      instr_retired
);
  logic [1:0] pipe_reg;
  logic [1:0] pipe_next;
  // Next instruction retires two cycles after resume
  always_comb pipe_next = {pipe_reg[0], resume};
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) pipe_reg <= 2'h0;
    else pipe_reg <= pipe_next;
  end
  assign instr_retired = pipe_reg[1];
endmodule : swc_core_model

// ---- verif/swc_chk.sv ----
// Purpose: Port checks of the sleep and wake controller
// Assumes: Single pclk domain
// Notes:   Global enable tracked from bus writes
`timescale 1ns/1ps
module swc_chk #(
  parameter int N_SRC = 8
) (
  // Clock, reset and bus writes
  input  wire logic             pclk,
  input  wire logic             presetn,
  input  wire logic             psel,
  input  wire logic             penable,
  input  wire logic             pwrite,
  input  wire logic [11:0]      paddr,
  input  wire logic [31:0]      pwdata,
  // Sources and core
  input  wire logic [N_SRC-1:0] src_enable,
  input  wire logic [N_SRC-1:0] src_flag,
  input  wire logic             sleep_exec,
  input  wire logic             instr_retired,
  input  wire logic             osc_stop,
  input  wire logic             core_halt,
  input  wire logic             resume,
  input  wire logic             vector_take,
  input  wire logic [12:0]      vector_addr
);
  logic glb_en_h;
  wire  wc = |(src_enable & src_flag);
  // Shadow of the global enable bit
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) glb_en_h <= 1'b0;
    else if (psel && penable && pwrite && paddr == 12'h000) glb_en_h <= pwdata[0];
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_halt_same: assert property (core_halt == osc_stop)
    else $error("halt and oscillator stop differ");
  a_sleep_enter: assert property (sleep_exec && !osc_stop && !glb_en_h && !$past(wc) |=> osc_stop)
    else $error("sleep not entered");
  a_sleep_noop: assert property (sleep_exec && !osc_stop && $past(wc) |=> !osc_stop)
    else $error("sleep taken with wake pending");
  a_int_wake: assert property (osc_stop && wc |=> !osc_stop && resume)
    else $error("no immediate wake");
  a_resume_fall: assert property (resume |-> $fell(osc_stop))
    else $error("resume without leaving sleep");
  a_vec_addr: assert property (vector_take |-> vector_addr == 13'h0004)
    else $error("wrong vector address");
  a_vec_retire: assert property (vector_take |-> $past(instr_retired))
    else $error("vector before next instruction");
  a_vec_global: assert property (vector_take |-> glb_en_h)
    else $error("vector with global enable clear");
endmodule : swc_chk
bind sleep_wake_control swc_chk #(.N_SRC(N_SRC)) i_swc_chk (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .src_enable(src_enable), .src_flag(src_flag), .sleep_exec(sleep_exec),
  .instr_retired(instr_retired), .osc_stop(osc_stop), .core_halt(core_halt),
  .resume(resume), .vector_take(vector_take), .vector_addr(vector_addr));

// ---- verif/test_sleep_wake_control.sv ----
// Purpose: Directed bench of the sleep and wake controller
// Assumes: Zero wait state bus, watchdog left enabled
// Notes:   Run spans a full watchdog period of 16384 cycles
`timescale 1ns/1ps
module test_sleep_wake_control;
  logic        pclk, presetn, psel, penable, pwrite, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [7:0]  src_enable, src_flag;
  logic        sleep_exec, wd_clear_exec, instr_retired, pready, pslverr;
  logic        osc_stop, core_halt, resume, vector_take, wdt_reset_req, irq;
  logic [12:0] vector_addr;
  int          errors, tests_run;

  sleep_wake_control i_sleep_wake_control (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
    .prdata(prdata), .pslverr(pslverr), .src_enable(src_enable), .src_flag(src_flag),
    .sleep_exec(sleep_exec), .wd_clear_exec(wd_clear_exec), .instr_retired(instr_retired),
    .osc_stop(osc_stop), .core_halt(core_halt), .resume(resume), .vector_take(vector_take),
    .vector_addr(vector_addr), .wdt_reset_req(wdt_reset_req), .irq(irq));
  swc_core_model i_swc_core_model (.pclk(pclk), .presetn(presetn), .resume(resume),
    .instr_retired(instr_retired));

  initial begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end

  task automatic wrap_up;
    $display("Comparisons %0d mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : wrap_up

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask : chk

  // One bus transfer, held until pready
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int i;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    for (i = 0; i < 20; i++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    if (i == 20) begin
      $display("[FAIL] pready expected 1 seen timeout");
      errors++;
      wrap_up();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // Core instruction pulse, then one settle edge
  task automatic step(input logic s, input logic c);
    @(posedge pclk);
    sleep_exec <= s;
    wd_clear_exec <= c;
    @(posedge pclk);
    sleep_exec <= 1'b0;
    wd_clear_exec <= 1'b0;
    @(posedge pclk);
  endtask : step

  // Bounded wait on one output: 0 resume, 1 vector, 2 watchdog reset
  task automatic wait_hi(input int sel, input int lim, input string n);
    int i;
    logic s;
    for (i = 0; i < lim; i++) begin
      @(posedge pclk);
      s = (sel == 0) ? resume : ((sel == 1) ? vector_take : wdt_reset_req);
      if (s === 1'b1) break;
    end
    if (i == lim) begin
      $display("[FAIL] %s expected 1 seen timeout", n);
      errors++;
      wrap_up();
    end
  endtask : wait_hi

  initial begin
    {psel, penable, pwrite, sleep_exec, wd_clear_exec} = 5'h00;
    paddr = 12'h000;
    pwdata = 32'h0;
    src_enable = 8'h08;
    src_flag = 8'h00;
    errors = 0;
    tests_run = 0;
    presetn = 1'b0;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, 12'h000, 32'h0);
    chk("ctrl reset", 32'h2, rd);
    apb(1'b0, 12'h010, 32'h0);
    chk("unmapped error", 32'h1, {31'h0, err});
    $display("reset test done");
    // Full sleep, interrupt wake, watchdog cleared
    step(1'b1, 1'b0);
    chk("osc stop", 32'h1, {31'h0, osc_stop});
    apb(1'b0, 12'h004, 32'h0);
    chk("status asleep", 32'h5, rd & 32'hffff);
    src_flag <= 8'h04;
    repeat (40) @(posedge pclk);
    chk("flag without enable", 32'h1, {31'h0, osc_stop});
    src_flag <= 8'h08;
    wait_hi(0, 50, "resume");
    src_flag <= 8'h00;
    apb(1'b0, 12'h004, 32'h0);
    chk("status woke", 32'h1, rd & 32'hffff);
    apb(1'b1, 12'h00c, 32'hf);
    @(posedge pclk);
    chk("irq raised", 32'h1, {31'h0, irq});
    apb(1'b1, 12'h008, 32'hf);
    @(posedge pclk);
    chk("irq cleared", 32'h0, {31'h0, irq});
    $display("sleep test done");
    // Wake pending before sleep
    step(1'b0, 1'b1);
    src_flag <= 8'h08;
    step(1'b1, 1'b0);
    chk("noop awake", 32'h0, {31'h0, osc_stop});
    apb(1'b0, 12'h004, 32'h0);
    chk("noop flags", 32'h3, rd & 32'h7);
    apb(1'b0, 12'h008, 32'h0);
    chk("noop event", 32'h2, rd & 32'h2);
    $display("noop test done");
    // Wake arising in the sleep cycle
    src_flag <= 8'h00;
    step(1'b0, 1'b1);
    sleep_exec <= 1'b1;
    src_flag <= 8'h08;
    @(posedge pclk);
    sleep_exec <= 1'b0;
    wait_hi(0, 50, "resume during");
    src_flag <= 8'h00;
    apb(1'b0, 12'h004, 32'h0);
    chk("during flags", 32'h1, rd & 32'h7);
    $display("during test done");
    // Global enable on: vector after next instruction
    apb(1'b1, 12'h000, 32'h3);
    step(1'b1, 1'b0);
    src_flag <= 8'h08;
    wait_hi(0, 50, "resume vector");
    src_flag <= 8'h00;
    wait_hi(1, 50, "vector take");
    chk("vector addr", 32'h4, {19'h0, vector_addr});
    $display("vector test done");
    // Watchdog runs out while awake: reset request, timeout flag low
    wait_hi(2, 20000, "watchdog reset");
    apb(1'b0, 12'h004, 32'h0);
    chk("timeout flag", 32'h0, rd & 32'h1);
    $display("watchdog test done");
    wrap_up();
  end
endmodule : test_sleep_wake_control
